// ### ihu_top.sv
// ihu_top: interrupt handling unit with pin edge logic, source flags,
// four-level priority nesting and vectored call request to the core.
// assumes core, peripherals and register port share SYS_CLK; pins async.
`timescale 1ns/100ps
`default_nettype none

module ihu_top #(
  parameter int SYNC_STAGES = 2
) (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        NRST,
  // register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [7:0]  WR_DATA,
  input  wire logic        WR_EN,
  input  wire logic        RD_EN,
  output logic      [7:0]  RD_DATA,
  // core side
  input  wire logic        SAMPLE_PHASE,
  input  wire logic        CORE_FINAL_MC,
  input  wire logic        CORE_RETURN_FROM_INTERRUPT,
  input  wire logic        CALL_ACK,
  output logic             CALL_REQ,
  output logic      [15:0] CALL_VECTOR,
  output logic      [1:0]  CALL_SP_INC,
  output logic      [3:0]  LEVEL_ACTIVE,
  // peripherals
  input  wire logic [1:0]  TIMER_OVF,
  output logic      [1:0]  TIMER_RUN,
  input  wire logic        UART_REQ,
  input  wire logic [7:0]  PERIPH_EVT_LOW,
  input  wire logic [1:0]  PERIPH_EVT_HIGH,
  // pins
  input  wire logic        EXT0_PIN_N,
  input  wire logic        EXT1_PIN_N,
  input  wire logic        EXTRA0_PIN,
  input  wire logic        EXTRA1_PIN
);

  if (SYNC_STAGES < 2) begin : g_chk
    $error("SYNC_STAGES must be at least 2");
  end

  localparam int NS = ihu_pkg::NUM_SRC;

  logic [7:0]  timer_and_ext_int_control_q, timer_and_ext_int_control_d;
  logic [7:0]  edge_q;
  logic [7:0]  src_lo_q, src_lo_d;
  logic [7:0]  src_hi_q, src_hi_d;
  logic [7:0]  ip0_q, ip1_q;
  logic [7:0]  en0_q, en1_q, en2_q;
  logic [3:0]  act_q, act_d;
  logic        defer_q;
  logic [NS-1:0] sampled_q;
  logic [3:0]  pin_mc_q;
  logic [7:0]  rd_q;
  ihu_pkg::ihu_state_t st_q, st_d;
  ihu_pkg::ihu_call_t  call_q, call_d;

  // register decode
  wire wr_timer_and_ext_int_control = WR_EN && (ADDR == ihu_pkg::ADDR_TMR_EXT_CTRL);
  wire wr_edge = WR_EN && (ADDR == ihu_pkg::ADDR_EDGE_SEL);
  wire wr_slo  = WR_EN && (ADDR == ihu_pkg::ADDR_SRC_LOW);
  wire wr_shi  = WR_EN && (ADDR == ihu_pkg::ADDR_SRC_HIGH);
  wire wr_ip0  = WR_EN && (ADDR == ihu_pkg::ADDR_PRIO_LOW);
  wire wr_ip1  = WR_EN && (ADDR == ihu_pkg::ADDR_PRIO_HIGH);
  wire wr_en0  = WR_EN && (ADDR == ihu_pkg::ADDR_EN0);
  wire wr_en1  = WR_EN && (ADDR == ihu_pkg::ADDR_EN1);
  wire wr_en2  = WR_EN && (ADDR == ihu_pkg::ADDR_EN2);
  wire wr_enip = wr_ip0 || wr_ip1 || wr_en0 || wr_en1 || wr_en2;

  // pin sync and machine-cycle edge detection
  wire [3:0] pin_raw = {EXTRA1_PIN, EXTRA0_PIN, EXT1_PIN_N, EXT0_PIN_N};
  wire [1:0] ext_type = {timer_and_ext_int_control_q[ihu_pkg::TC_EXT1_TYPE],
                         timer_and_ext_int_control_q[ihu_pkg::TC_EXT0_TYPE]};
  logic [3:0] pin_s;
  logic [3:0] edge_hit;
  logic [1:0] lvl_hit;

  for (genvar p = 0; p < ihu_pkg::NUM_PINS; p++) begin : g_pin
    logic [SYNC_STAGES-1:0] sync_q;
    always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
        sync_q <= {SYNC_STAGES{ihu_pkg::PIN_IDLE[p]}};
      end else begin
        sync_q <= {sync_q[SYNC_STAGES-2:0], pin_raw[p]};
      end
    end
    assign pin_s[p] = sync_q[SYNC_STAGES-1];
    wire rise_en = edge_q[2*p+1];
    wire fall_en = edge_q[2*p];
    wire rise = pin_s[p] && !pin_mc_q[p];
    wire fall = !pin_s[p] && pin_mc_q[p];
    // R24 R17 R18 R19
    assign edge_hit[p] = SAMPLE_PHASE && ((rise && rise_en) ||
                                          (fall && fall_en));
    if (p < 2) begin : g_lvl
      // R15
      assign lvl_hit[p] = (fall_en && !rise_en && !pin_s[p]) ||
                          (rise_en && !fall_en && pin_s[p]);
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      pin_mc_q <= ihu_pkg::PIN_IDLE;
    end else if (SAMPLE_PHASE) begin
      pin_mc_q <= pin_s;
    end
  end

  // vector clear on acknowledge
  wire ack     = CALL_ACK && call_q.req;
  wire clr_ie0 = ack && (call_q.src == ihu_pkg::SRC_EXT0);
  wire clr_ie1 = ack && (call_q.src == ihu_pkg::SRC_EXT1);
  wire clr_tf0 = ack && (call_q.src == ihu_pkg::SRC_TMR0);
  wire clr_tf1 = ack && (call_q.src == ihu_pkg::SRC_TMR1);

  // flag next values; hardware set wins over any clear
  always_comb begin
    timer_and_ext_int_control_d = wr_timer_and_ext_int_control ? WR_DATA : timer_and_ext_int_control_q;
    // R7 R16
    if (ext_type[0]) begin
      timer_and_ext_int_control_d[ihu_pkg::TC_EXT0_FLAG] = edge_hit[0] ||
        ((wr_timer_and_ext_int_control ? WR_DATA[ihu_pkg::TC_EXT0_FLAG]
                  : timer_and_ext_int_control_q[ihu_pkg::TC_EXT0_FLAG]) && !clr_ie0);
    end else begin
      timer_and_ext_int_control_d[ihu_pkg::TC_EXT0_FLAG] = lvl_hit[0];
    end
    if (ext_type[1]) begin
      timer_and_ext_int_control_d[ihu_pkg::TC_EXT1_FLAG] = edge_hit[1] ||
        ((wr_timer_and_ext_int_control ? WR_DATA[ihu_pkg::TC_EXT1_FLAG]
                  : timer_and_ext_int_control_q[ihu_pkg::TC_EXT1_FLAG]) && !clr_ie1);
    end else begin
      timer_and_ext_int_control_d[ihu_pkg::TC_EXT1_FLAG] = lvl_hit[1];
    end
    // R8
    timer_and_ext_int_control_d[ihu_pkg::TC_TMR0_OVF] = TIMER_OVF[0] ||
      ((wr_timer_and_ext_int_control ? WR_DATA[ihu_pkg::TC_TMR0_OVF]
                : timer_and_ext_int_control_q[ihu_pkg::TC_TMR0_OVF]) && !clr_tf0);
    timer_and_ext_int_control_d[ihu_pkg::TC_TMR1_OVF] = TIMER_OVF[1] ||
      ((wr_timer_and_ext_int_control ? WR_DATA[ihu_pkg::TC_TMR1_OVF]
                : timer_and_ext_int_control_q[ihu_pkg::TC_TMR1_OVF]) && !clr_tf1);
  end

  // R5 R9
  assign src_lo_d = PERIPH_EVT_LOW | (wr_slo ? WR_DATA : src_lo_q);
  assign src_hi_d = ihu_pkg::SRC_HIGH_MASK &
                    ({PERIPH_EVT_HIGH, 4'h0, edge_hit[3:2]} |
                     (wr_shi ? WR_DATA : src_hi_q));

  // request vector in scan order
  wire [NS-1:0] req_raw = {
    src_hi_q[6], src_lo_q[0], src_lo_q[3], src_lo_q[6], src_lo_q[7],
    src_lo_q[1], src_lo_q[4], UART_REQ, src_hi_q[7], src_hi_q[1],
    timer_and_ext_int_control_q[ihu_pkg::TC_TMR1_OVF], src_lo_q[2], src_lo_q[5],
    timer_and_ext_int_control_q[ihu_pkg::TC_EXT1_FLAG], src_hi_q[0],
    timer_and_ext_int_control_q[ihu_pkg::TC_TMR0_OVF], timer_and_ext_int_control_q[ihu_pkg::TC_EXT0_FLAG]};
  wire [23:0] en_all = {en2_q, en1_q, en0_q};

  // per-source level and eligibility
  logic [NS-1:0][1:0] src_lvl;
  logic [NS-1:0]      elig;
  for (genvar i = 0; i < NS; i++) begin : g_src
    localparam logic [2:0] G = ihu_pkg::SRC_GROUP[i];
    // R21
    assign src_lvl[i] = {ip1_q[G], ip0_q[G]};
    // R2 R14
    assign elig[i] = sampled_q[i] && ((act_q >> src_lvl[i]) == 4'h0);
  end

  // winner: highest level, then lowest scan index
  logic       found;
  logic [4:0] win;
  logic [1:0] win_lvl;
  always_comb begin
    found   = 1'b0;
    win     = 5'h00;
    win_lvl = 2'h0;
    for (int l = ihu_pkg::NUM_LVL - 1; l >= 0; l--) begin
      for (int i = 0; i < NS; i++) begin
        // R22
        if (!found && elig[i] && (src_lvl[i] == l[1:0])) begin
          found   = 1'b1;
          win     = i[4:0];
          win_lvl = l[1:0];
        end
      end
    end
  end

  // R1 R2 R3 R6
  wire issue = SAMPLE_PHASE && (st_q == ihu_pkg::ST_IDLE) && found &&
               en2_q[ihu_pkg::EN2_GLOBAL] && !defer_q &&
               !CORE_FINAL_MC && !CORE_RETURN_FROM_INTERRUPT;
  wire [3:0] top_oh = act_q[3] ? 4'h8 : act_q[2] ? 4'h4 :
                      act_q[1] ? 4'h2 : act_q[0] ? 4'h1 : 4'h0;

  always_comb begin
    st_d   = st_q;
    call_d = call_q;
    act_d  = act_q;
    case (st_q)
      ihu_pkg::ST_IDLE: begin
        if (issue) begin
          st_d          = ihu_pkg::ST_CALL;
          call_d.req    = 1'b1;
          call_d.level  = win_lvl;
          call_d.src    = win;
          // R23
          call_d.vector = {8'h00, ihu_pkg::SRC_VIDX[win],
                           ihu_pkg::VEC_LOW_BITS};
          // R12 R13
          call_d.sp_inc = ihu_pkg::PC_PUSH_BYTES;
          act_d         = act_q | (4'h1 << win_lvl);
        end
      end
      ihu_pkg::ST_CALL: begin
        if (CALL_ACK) begin
          st_d       = ihu_pkg::ST_IDLE;
          call_d.req = 1'b0;
        end
      end
      default: begin
        st_d   = ihu_pkg::ST_IDLE;
        call_d = '0;
      end
    endcase
    // R11
    if (CORE_RETURN_FROM_INTERRUPT && !issue) begin
      act_d = act_d & ~top_oh;
    end
  end

  // read selection
  wire [7:0] rd_mux =
    (ADDR == ihu_pkg::ADDR_TMR_EXT_CTRL) ? timer_and_ext_int_control_q   :
    (ADDR == ihu_pkg::ADDR_EDGE_SEL)     ? edge_q   :
    (ADDR == ihu_pkg::ADDR_SRC_LOW)      ? src_lo_q :
    (ADDR == ihu_pkg::ADDR_SRC_HIGH)     ? src_hi_q :
    (ADDR == ihu_pkg::ADDR_PRIO_LOW)     ? {2'h0, ip0_q[5:0]} :
    (ADDR == ihu_pkg::ADDR_PRIO_HIGH)    ? {2'h0, ip1_q[5:0]} :
    (ADDR == ihu_pkg::ADDR_EN0)          ? en0_q    :
    (ADDR == ihu_pkg::ADDR_EN1)          ? en1_q    :
    (ADDR == ihu_pkg::ADDR_EN2)          ? en2_q    :
    (ADDR == ihu_pkg::ADDR_LVL_STATUS)   ? {4'h0, act_q} : 8'h00;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      timer_and_ext_int_control_q   <= ihu_pkg::RST_TMR_EXT_CTRL;
      src_lo_q <= ihu_pkg::RST_ZERO;
      src_hi_q <= ihu_pkg::RST_ZERO;
      rd_q     <= ihu_pkg::RST_ZERO;
    end else begin
      timer_and_ext_int_control_q   <= timer_and_ext_int_control_d;
      src_lo_q <= src_lo_d;
      src_hi_q <= src_hi_d;
      rd_q     <= RD_EN ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      edge_q <= ihu_pkg::RST_EDGE_SEL;
      ip0_q  <= ihu_pkg::RST_ZERO;
      ip1_q  <= ihu_pkg::RST_ZERO;
      en0_q  <= ihu_pkg::RST_ZERO;
      en1_q  <= ihu_pkg::RST_ZERO;
      en2_q  <= ihu_pkg::RST_ZERO;
    end else begin
      if (wr_edge) edge_q <= WR_DATA;
      if (wr_ip0)  ip0_q  <= {2'h0, WR_DATA[5:0]};
      if (wr_ip1)  ip1_q  <= {2'h0, WR_DATA[5:0]};
      if (wr_en0)  en0_q  <= WR_DATA;
      if (wr_en1)  en1_q  <= WR_DATA;
      if (wr_en2)  en2_q  <= WR_DATA;
    end
  end

  // R1 R4: sampled set lives one machine cycle only
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      sampled_q <= '0;
      defer_q   <= 1'b0;
    end else begin
      if (SAMPLE_PHASE) sampled_q <= req_raw & en_all[NS-1:0];
      defer_q <= CORE_RETURN_FROM_INTERRUPT || wr_enip || (defer_q && !SAMPLE_PHASE); // R3
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      st_q   <= ihu_pkg::ST_IDLE;
      call_q <= '0;
      act_q  <= 4'h0;
    end else begin
      st_q   <= st_d;
      call_q <= call_d;
      act_q  <= act_d;
    end
  end

  assign RD_DATA      = rd_q;
  assign CALL_REQ     = call_q.req;
  assign CALL_VECTOR  = call_q.vector;
  assign CALL_SP_INC  = call_q.sp_inc;
  assign LEVEL_ACTIVE = act_q;
  assign TIMER_RUN    = {timer_and_ext_int_control_q[ihu_pkg::TC_TMR1_RUN],
                         timer_and_ext_int_control_q[ihu_pkg::TC_TMR0_RUN]};

  // checks
  sequence s_issue;
    SAMPLE_PHASE && st_q == ihu_pkg::ST_IDLE ##1 call_q.req;
  endsequence
  sequence s_fall0;
    SAMPLE_PHASE && ext_type[0] && edge_q[0] && pin_mc_q[0] && !pin_s[0];
  endsequence

  a_sample_hold: assert property (@(posedge SYS_CLK) disable iff (!NRST) // R1
    !SAMPLE_PHASE |=> $stable(sampled_q))
    else $error("sampled set changed outside sample phase");
  a_level_block: assert property (@(posedge SYS_CLK) disable iff (!NRST) // R2
    $rose(call_q.req) |-> (($past(act_q) >> call_q.level) == 4'h0))
    else $error("call issued at or below an active level");
  a_defer_poll: assert property (@(posedge SYS_CLK) disable iff (!NRST) // R3
    (SAMPLE_PHASE && defer_q && !call_q.req) |=> !call_q.req)
    else $error("call issued in a deferred poll");
  a_multi_block: assert property (@(posedge SYS_CLK) disable iff (!NRST) // R2
    (SAMPLE_PHASE && CORE_FINAL_MC && !call_q.req) |=> !call_q.req)
    else $error("call issued on final multicycle cycle");
  a_flags_kept: assert property (@(posedge SYS_CLK) disable iff (!NRST) // R5
    !wr_slo |=> ((src_lo_q & $past(src_lo_q)) == $past(src_lo_q)))
    else $error("source flag lost without software write");
  a_tmr_clear: assert property (@(posedge SYS_CLK) disable iff (!NRST) // R8
    (clr_tf0 && !wr_timer_and_ext_int_control) |=> (!timer_and_ext_int_control_q[ihu_pkg::TC_TMR0_OVF] ||
                               $past(TIMER_OVF[0])))
    else $error("timer 0 flag not cleared on vectoring");
  a_edge_flag: assert property (@(posedge SYS_CLK) disable iff (!NRST) // R16
    s_fall0 |=> timer_and_ext_int_control_q[ihu_pkg::TC_EXT0_FLAG])
    else $error("falling edge did not set ext0 flag");
  a_return_from_interrupt_clear: assert property (@(posedge SYS_CLK) disable iff (!NRST) // R11
    (CORE_RETURN_FROM_INTERRUPT && !issue) |=> act_q == ($past(act_q) & ~$past(top_oh)))
    else $error("return did not clear the top active level");
  a_call_form: assert property (@(posedge SYS_CLK) disable iff (!NRST) // R23
    s_issue |-> (CALL_VECTOR[2:0] == 3'h3 && CALL_SP_INC == 2'h2 &&
                 act_q[call_q.level]))
    else $error("call vector, stack step or level flop wrong");

endmodule

`default_nettype wire

// ### ihu_pkg.sv
// ihu_pkg: register map, field positions, source tables and types for
// the interrupt handling unit. assumes an 8-bit register port and a core
// that marks the sample phase of each machine cycle with a one-cycle pulse.
// Operation
// R1: sample requests each machine cycle, poll next
// R2: serve only above active level, not final multicycle
// R3: defer after return or enable/priority write
// R4: core requests held one machine cycle only
// R5: other requests latched until software clears
// R6: single-source response within three to nine cycles
// R7: ext edge flag cleared on vector; level follows pin
// R8: timer overflow flags cleared on vectoring
// R9: other flags cleared only by software
// R10: software ends every handler with return
// R11: one active flop per level, return clears it
// R12: acknowledge sets level flop, calls without status
// R13: nested call pushes address, stack plus two
// R14: after return lower levels stay blocked
// R15: type, rise, fall bits select pin mode
// R16: edge mode sets flag on qualifying edge
// R17: ext0 pin has rise and fall enables
// R18: ext1 pin has rise and fall enables
// R19: extra pins edge only, own enables
// R20: software spaces interrupts when both edges enabled
// R21: six groups, two-bit level from two registers
// R22: equal level resolved by fixed scan order
// R23: call to fixed vector per source
// R24: edge from successive machine-cycle pin samples
package ihu_pkg;

  // register offsets
  localparam logic [7:0] ADDR_TMR_EXT_CTRL = 8'h88;
  localparam logic [7:0] ADDR_EDGE_SEL     = 8'had;
  localparam logic [7:0] ADDR_SRC_LOW      = 8'hc0;
  localparam logic [7:0] ADDR_SRC_HIGH     = 8'hc8;
  localparam logic [7:0] ADDR_PRIO_LOW     = 8'hb8;
  localparam logic [7:0] ADDR_PRIO_HIGH    = 8'hb9;
  localparam logic [7:0] ADDR_EN0          = 8'ha8;
  localparam logic [7:0] ADDR_EN1          = 8'ha9;
  localparam logic [7:0] ADDR_EN2          = 8'haa;
  localparam logic [7:0] ADDR_LVL_STATUS   = 8'hab;

  // reset values
  localparam logic [7:0] RST_TMR_EXT_CTRL = 8'h00;
  localparam logic [7:0] RST_EDGE_SEL     = 8'h05;
  localparam logic [7:0] RST_ZERO         = 8'h00;
  // idle pin levels: ext pins high, extra pins low
  localparam logic [3:0] PIN_IDLE         = 4'h3;

  // timer_and_ext_int_control fields
  localparam int TC_EXT0_TYPE = 0;
  localparam int TC_EXT0_FLAG = 1;
  localparam int TC_EXT1_TYPE = 2;
  localparam int TC_EXT1_FLAG = 3;
  localparam int TC_TMR0_RUN  = 4;
  localparam int TC_TMR0_OVF  = 5;
  localparam int TC_TMR1_RUN  = 6;
  localparam int TC_TMR1_OVF  = 7;

  // source_flags_high implemented bits and enable2 global bit
  localparam logic [7:0] SRC_HIGH_MASK = 8'hc3;
  localparam int         EN2_GLOBAL    = 7;

  localparam int NUM_SRC  = 17;
  localparam int NUM_GRP  = 6;
  localparam int NUM_LVL  = 4;
  localparam int NUM_PINS = 4;

  // scan order: group first, then column inside the group
  localparam logic [4:0] SRC_EXT0 = 5'h00;
  localparam logic [4:0] SRC_TMR0 = 5'h01;
  localparam logic [4:0] SRC_EXT1 = 5'h03;
  localparam logic [4:0] SRC_TMR1 = 5'h06;

  localparam logic [NUM_SRC-1:0][2:0] SRC_GROUP = {
    3'h5, 3'h5, 3'h5, 3'h5, 3'h4, 3'h4, 3'h4, 3'h4, 3'h3,
    3'h3, 3'h3, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0};
  localparam logic [NUM_SRC-1:0][4:0] SRC_VIDX = {
    5'h19, 5'h13, 5'h0b, 5'h05, 5'h18, 5'h12, 5'h0a, 5'h04, 5'h11,
    5'h09, 5'h03, 5'h10, 5'h08, 5'h02, 5'h07, 5'h01, 5'h00};
  localparam logic [2:0] VEC_LOW_BITS  = 3'h3;
  localparam logic [1:0] PC_PUSH_BYTES = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CALL = 2'b10
  } ihu_state_t;

  typedef struct packed {
    logic        req;
    logic [1:0]  level;
    logic [4:0]  src;
    logic [15:0] vector;
    logic [1:0]  sp_inc;
  } ihu_call_t;

endpackage

// ### ihu_core_model.sv
// ihu_core_model: core side of the interrupt unit; marks the sample
// phase once per machine cycle and performs each requested call.
// assumes call request stays up until the edge after the acknowledge.
`timescale 1ns/100ps
`default_nettype none

module ihu_core_model #(
  parameter int MC_LEN = 6
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // call handshake
  input  wire logic       call_req,
  input  wire logic [3:0] ack_dly,
  output logic            call_ack,
  // machine cycle
  output logic            sample_phase
);
  int unsigned ph_q;
  int unsigned wait_q;

  // one sample pulse per machine cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ph_q         <= 0;
      sample_phase <= 1'b0;
    end else begin
      ph_q         <= (ph_q == MC_LEN - 1) ? 0 : ph_q + 1;
      sample_phase <= (ph_q == MC_LEN - 1);
    end
  end

  // pc pushed and vector taken after a chosen delay, one ack per call
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wait_q   <= 0;
      call_ack <= 1'b0;
    end else begin
      call_ack <= 1'b0;
      if (!call_req || call_ack) begin
        wait_q <= 0;
      end else if (wait_q >= ack_dly) begin
        call_ack <= 1'b1;
        wait_q   <= 0;
      end else begin
        wait_q <= wait_q + 1;
      end
    end
  end
endmodule

`default_nettype wire

// ### ihu_tb.sv
// tb: self-checking bench for the interrupt handling unit; drives the
// register port, peripheral events and pins, checks calls and flags.
// assumes ihu_pkg, ihu_top and ihu_core_model are compiled before it.
`timescale 1ns/100ps
`default_nettype none

module tb;
  localparam int MC = 6;
  logic        SYS_CLK = 1'b0;
  logic        NRST = 1'b0;
  logic [7:0]  ADDR = 8'h00;
  logic [7:0]  WR_DATA = 8'h00;
  logic        WR_EN = 1'b0;
  logic        RD_EN = 1'b0;
  logic        CORE_FINAL_MC = 1'b0;
  logic        CORE_RETURN_FROM_INTERRUPT = 1'b0;
  logic        UART_REQ = 1'b0;
  logic [1:0]  TIMER_OVF = 2'h0;
  logic [7:0]  PERIPH_EVT_LOW = 8'h00;
  logic [1:0]  PERIPH_EVT_HIGH = 2'h0;
  logic [1:0]  EXT_PIN_N = 2'h3;
  logic [1:0]  EXTRA_PIN = 2'h0;
  logic [3:0]  ack_dly = 4'h2;
  logic [7:0]  RD_DATA;
  logic [15:0] CALL_VECTOR;
  logic [1:0]  CALL_SP_INC;
  logic [1:0]  TIMER_RUN;
  logic [3:0]  LEVEL_ACTIVE;
  logic        SAMPLE_PHASE;
  logic        CALL_ACK;
  logic        CALL_REQ;
  logic [2:0]  m;
  int          n_mismatch = 0;
  int          check_count = 0;

  always #2.5 SYS_CLK = ~SYS_CLK;

  ihu_top u_dut (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
    .SAMPLE_PHASE(SAMPLE_PHASE), .CORE_FINAL_MC(CORE_FINAL_MC),
    .CORE_RETURN_FROM_INTERRUPT(CORE_RETURN_FROM_INTERRUPT), .CALL_ACK(CALL_ACK), .CALL_REQ(CALL_REQ),
    .CALL_VECTOR(CALL_VECTOR), .CALL_SP_INC(CALL_SP_INC),
    .LEVEL_ACTIVE(LEVEL_ACTIVE), .TIMER_OVF(TIMER_OVF),
    .TIMER_RUN(TIMER_RUN), .UART_REQ(UART_REQ),
    .PERIPH_EVT_LOW(PERIPH_EVT_LOW), .PERIPH_EVT_HIGH(PERIPH_EVT_HIGH),
    .EXT0_PIN_N(EXT_PIN_N[0]), .EXT1_PIN_N(EXT_PIN_N[1]),
    .EXTRA0_PIN(EXTRA_PIN[0]), .EXTRA1_PIN(EXTRA_PIN[1]));

  ihu_core_model #(.MC_LEN(MC)) u_core (
    .sys_clk(SYS_CLK), .nrst(NRST), .call_req(CALL_REQ),
    .ack_dly(ack_dly), .call_ack(CALL_ACK), .sample_phase(SAMPLE_PHASE));

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR    <= a;
    WR_DATA <= d;
    WR_EN   <= 1'b1;
    @(posedge SYS_CLK);
    WR_EN <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [7:0] e);
    @(posedge SYS_CLK);
    ADDR  <= a;
    RD_EN <= 1'b1;
    @(posedge SYS_CLK);
    RD_EN <= 1'b0;
    #1;
    chk(what, {8'h00, e}, {8'h00, RD_DATA});
  endtask

  task automatic mcs(input int n);
    repeat (n * MC) @(posedge SYS_CLK);
  endtask

  task automatic evt(input logic [1:0] t, input logic [7:0] p);
    @(posedge SYS_CLK);
    TIMER_OVF      <= t;
    PERIPH_EVT_LOW <= p;
    @(posedge SYS_CLK);
    TIMER_OVF      <= 2'h0;
    PERIPH_EVT_LOW <= 8'h00;
  endtask

  // wait for a call, check it, let the core model perform it
  task automatic serve(input logic [15:0] vec, input logic [3:0] lvl);
    int i;
    i = 0;
    ack_dly <= 4'h2 + 4'($urandom % 8);
    while (CALL_REQ !== 1'b1 && i < 9 * MC) begin
      @(posedge SYS_CLK);
      #1;
      i++;
    end
    chk("call_req", 16'h1, {15'h0, CALL_REQ});
    chk("call_vector", vec, CALL_VECTOR);
    chk("call_sp_inc", 16'h2, {14'h0, CALL_SP_INC});
    chk("level_active", {12'h0, lvl}, {12'h0, LEVEL_ACTIVE});
    while (CALL_REQ === 1'b1 && i < 30 * MC) begin
      @(posedge SYS_CLK);
      #1;
      i++;
    end
  endtask

  task automatic return_from_interrupt(input logic [3:0] lvl);
    @(posedge SYS_CLK);
    CORE_RETURN_FROM_INTERRUPT <= 1'b1;
    @(posedge SYS_CLK);
    CORE_RETURN_FROM_INTERRUPT <= 1'b0;
    @(posedge SYS_CLK);
    #1;
    chk("level_after_ret", {12'h0, lvl}, {12'h0, LEVEL_ACTIVE});
  endtask

  task automatic no_call(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n * MC) begin
      @(posedge SYS_CLK);
      #1;
      if (CALL_REQ !== 1'b0) seen = 1'b1;
    end
    chk("call_held_off", 16'h0, {15'h0, seen});
  endtask

  // flag seen after a pin fall or rise for mode {type, rise, fall}
  function automatic logic ext_exp(input logic [2:0] md, input logic fall);
    if (md[2]) return fall ? md[0] : md[1];
    return fall ? (md[0] & ~md[1]) : (md[1] & ~md[0]);
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge SYS_CLK);
    n_mismatch++;
    test_done();
  end

  initial begin
    void'($urandom(32'h430c));
    repeat (12) @(posedge SYS_CLK);
    NRST <= 1'b1;
    rchk("tmr_ext_ctrl", 8'h88, 8'h00);
    rchk("edge_sel", 8'had, 8'h05);
    rchk("src_high", 8'hc8, 8'h00);
    rchk("unmapped", 8'h10, 8'h00);
    wr(8'h88, 8'h50);
    #1 chk("timer_run", 16'h3, {14'h0, TIMER_RUN});
    $display("test reset done");
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 8; k++) begin
        m = k[2:0];
        wr(8'had, {6'h0, m[1:0]} << (2 * p));
        wr(8'h88, {7'h0, m[2]} << (2 * p));
        mcs(3);
        EXT_PIN_N[p] <= 1'b0;
        mcs(3);
        rchk("ext_fall", 8'h88,
             {6'h0, ext_exp(m, 1'b1), m[2]} << (2 * p));
        wr(8'h88, {7'h0, m[2]} << (2 * p));
        EXT_PIN_N[p] <= 1'b1;
        mcs(3);
        rchk("ext_rise", 8'h88,
             {6'h0, ext_exp(m, 1'b0), m[2]} << (2 * p));
      end
    end
    for (int p = 0; p < 2; p++) begin
      wr(8'had, 8'h20 << (2 * p));
      EXTRA_PIN[p] <= 1'b1;
      mcs(3);
      rchk("extra_rise", 8'hc8, 8'h01 << p);
      wr(8'hc8, 8'h00);
      EXTRA_PIN[p] <= 1'b0;
      mcs(3);
      rchk("extra_fall_off", 8'hc8, 8'h00);
    end
    m = 3'($urandom % 8);
    evt(2'h0, 8'h01 << m);
    @(posedge SYS_CLK);
    PERIPH_EVT_HIGH <= 2'h3;
    @(posedge SYS_CLK);
    PERIPH_EVT_HIGH <= 2'h0;
    mcs(2 + $urandom % 6);
    rchk("src_low_kept", 8'hc0, 8'h01 << m);
    rchk("src_high_kept", 8'hc8, 8'hc0);
    wr(8'hc0, 8'h00);
    wr(8'hc8, 8'h00);
    $display("test pins and flags done");
    wr(8'had, 8'h01);
    wr(8'h88, 8'h01);
    wr(8'ha8, 8'h53);
    EXT_PIN_N[0] <= 1'b0;
    evt(2'h1, 8'h20);
    mcs(3);
    wr(8'haa, 8'h80);
    serve(16'h0003, 4'h1);
    EXT_PIN_N[0] <= 1'b1;
    rchk("ext0_cleared", 8'h88, 8'h21);
    no_call(3);
    return_from_interrupt(4'h0);
    serve(16'h000b, 4'h1);
    rchk("tf0_cleared", 8'h88, 8'h01);
    return_from_interrupt(4'h0);
    serve(16'h0043, 4'h1);
    rchk("wdt_kept", 8'hc0, 8'h20);
    wr(8'hc0, 8'h00);
    return_from_interrupt(4'h0);
    no_call(3);
    $display("test service done");
    wr(8'hb8, 8'h0a);
    wr(8'hb9, 8'h0c);
    evt(2'h1, 8'h00);
    serve(16'h000b, 4'h2);
    evt(2'h0, 8'h20);
    serve(16'h0043, 4'h6);
    evt(2'h2, 8'h00);
    serve(16'h001b, 4'he);
    evt(2'h1, 8'h00);
    return_from_interrupt(4'h6);
    no_call(2);
    wr(8'hc0, 8'h00);
    return_from_interrupt(4'h2);
    no_call(2);
    return_from_interrupt(4'h0);
    serve(16'h000b, 4'h2);
    return_from_interrupt(4'h0);
    wr(8'hb8, 8'h00);
    wr(8'hb9, 8'h00);
    $display("test nesting done");
    CORE_FINAL_MC <= 1'b1;
    evt(2'h1, 8'h00);
    no_call(4);
    CORE_FINAL_MC <= 1'b0;
    serve(16'h000b, 4'h1);
    return_from_interrupt(4'h0);
    evt(2'h1, 8'h00);
    fork
      no_call(5);
      repeat (5) begin
        wr(8'ha8, 8'h13);
        repeat (MC - 2) @(posedge SYS_CLK);
      end
    join
    serve(16'h000b, 4'h1);
    return_from_interrupt(4'h0);
    wr(8'ha9, 8'h02);
    CORE_FINAL_MC <= 1'b1;
    UART_REQ      <= 1'b1;
    mcs(1);
    UART_REQ <= 1'b0;
    mcs(2);
    CORE_FINAL_MC <= 1'b0;
    no_call(4);
    UART_REQ <= 1'b1;
    serve(16'h0023, 4'h1);
    UART_REQ <= 1'b0;
    return_from_interrupt(4'h0);
    $display("test deferral done");
    test_done();
  end
endmodule

`default_nettype wire
